// >>> hw/sct_defs.svh
// Register offsets, field positions, reset values and bit timing counts
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

// Register byte offsets on the APB
`define SCT_OFF_CMD     8'h00
`define SCT_OFF_MODE    8'h04
`define SCT_OFF_MODE2   8'h08
`define SCT_OFF_TBUF    8'h0c
`define SCT_OFF_STATUS  8'h10
`define SCT_OFF_INT_ST  8'h14
`define SCT_OFF_INT_CLR 8'h18
`define SCT_OFF_INT_EN  8'h1c

// Command register bit positions
`define SCT_CMD_ENA 0
`define SCT_CMD_DIS 1

// Event bit positions, shared by status, clear and enable registers
`define SCT_EVT_READY 0
`define SCT_EVT_EMPTY 1

// Reset values: eight data bits, no parity, 16x clock, one stop bit
`define SCT_MODE_RST  5'h03
`define SCT_MODE2_RST 6'h07

// Clock source ticks per bit and stop length offsets in sixteenths
`define SCT_TICKS_16X  6'h10
`define SCT_TICKS_1X   6'h01
`define SCT_STOP_TWO   6'h02
`define SCT_STOP_SHORT 6'h09
`define SCT_STOP_LONG  6'h11
`define SCT_LEN_5BIT   2'h0
`define SCT_DBITS_BASE 3'h4
`define SCT_DBITS_MIN  4'h5

`endif

// >>> hw/sct_pkg.sv
// Types shared by the serial character transmitter
package sct_pkg;

    // Phase of the character being sent
    typedef enum logic [2:0] {
        SCT_IDLE,
        SCT_START,
        SCT_DATA,
        SCT_PARITY,
        SCT_STOP
    } sct_phase_t;

    // First mode register: length code 0..3 means 5..8 data bits
    typedef struct packed {
        logic       one_x;
        logic       par_odd;
        logic       par_en;
        logic [1:0] len;
    } sct_mode_t;

    // Second mode register
    typedef struct packed {
        logic       rts_ctl;
        logic       cts_gate;
        logic [3:0] stop_sel;
    } sct_mode2_t;

    // Whole state of the transmitter
    typedef struct packed {
        sct_mode_t   mode;
        sct_mode2_t  mode2;
        logic        enabled;
        logic [7:0]  tbuf;
        logic        tb_full;
        logic [7:0]  shifter;
        sct_phase_t  phase;
        logic [5:0]  cnt;
        logic [2:0]  idx;
        logic        par;
        logic        txd;
        logic        empty;
        logic        ready_q;
        logic        bclk_q;
        logic [1:0]  ist;
        logic [1:0]  ien;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sct_state_t;

    // State of one pin filter
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sct_filt_t;

endpackage : sct_pkg

// >>> hw/sct_pin_filter.sv
// Three-stage pin synchroniser with an agreement filter
`timescale 1ns/10ps
`default_nettype none

module sct_pin_filter #(
    parameter logic RST_LVL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level
);

    sct_pkg::sct_filt_t s;
    sct_pkg::sct_filt_t next_s;

    // Stage one feeds only stage two; the level moves once two and three agree
    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.lvl = s.s3;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= {4{RST_LVL}};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.lvl;  // Straight from a flop

endmodule : sct_pin_filter

`default_nettype wire

// >>> hw/sct_transmitter.sv
// Transmit half of an asynchronous serial channel with APB registers
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.svh"


module sct_transmitter (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_clock_source,
    input  wire logic        clear_to_send_n,
    output logic             serial_tx_output,
    output logic             irq
);

    localparam sct_pkg::sct_state_t RST_STATE = '{
        mode:    `SCT_MODE_RST,
        mode2:   `SCT_MODE2_RST,
        enabled: 1'b0,
        tbuf:    8'h00,
        tb_full: 1'b0,
        shifter: 8'h00,
        phase:   sct_pkg::SCT_IDLE,
        cnt:     6'h00,
        idx:     3'h0,
        par:     1'b0,
        txd:     1'b1,
        empty:   1'b1,
        ready_q: 1'b0,
        bclk_q:  1'b1,
        ist:     2'h0,
        ien:     2'h0,
        irq:     1'b0,
        prdata:  32'h0000_0000,
        pready:  1'b0,
        pslverr: 1'b0
    };

    sct_pkg::sct_state_t s;
    sct_pkg::sct_state_t next_s;
    logic                bclk_lvl;
    logic                cts_n_lvl;
    logic                tick;
    logic                cts_ok;
    logic                can_start;
    logic                go_load;
    logic                acc;
    logic                wr_go;
    logic                wr_tb;
    logic [5:0]          bit_len;
    logic [5:0]          stop_len;
    logic [2:0]          last_idx;
    logic [7:0]          data_mask;
    logic [1:0]          ev;
    logic [1:0]          clr;

    // Both pins arrive from outside the clock domain
    sct_pin_filter #(
        .RST_LVL (1'b1)
    ) u_bclk (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (tx_clock_source),
        .level   (bclk_lvl)
    );

    // Clear-to-send is active low, so it rests negated at reset
    sct_pin_filter #(
        .RST_LVL (1'b1)
    ) u_cts (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (clear_to_send_n),
        .level   (cts_n_lvl)
    );

    // Stop length in clock source ticks
    function automatic logic [5:0] stop_ticks(
        input sct_pkg::sct_mode_t m,
        input logic [3:0]         sel
    );
        logic [5:0] t;
        t = {2'b00, sel} + `SCT_STOP_LONG;
        if (m.one_x) begin
            t = sel[3] ? `SCT_STOP_TWO : `SCT_TICKS_1X;
        end else if (!sel[3] && m.len != `SCT_LEN_5BIT) begin
            t = {2'b00, sel} + `SCT_STOP_SHORT;
        end
        return t;
    endfunction : stop_ticks

    // Derived timing, gating and bus terms
    always_comb begin
        tick      = s.bclk_q & ~bclk_lvl;
        bit_len   = s.mode.one_x ? `SCT_TICKS_1X : `SCT_TICKS_16X;
        stop_len  = stop_ticks(s.mode, s.mode2.stop_sel);
        last_idx  = `SCT_DBITS_BASE + {1'b0, s.mode.len};
        data_mask = ~(8'hff << (`SCT_DBITS_MIN + {2'b00, s.mode.len}));
        // Request-to-send control has no say here, gating alone decides
        cts_ok    = ~cts_n_lvl | ~s.mode2.cts_gate;
        can_start = s.enabled & s.tb_full & cts_ok;
        acc       = psel & penable & ~s.pready;
        wr_go     = psel & penable & pwrite & s.pready;
        // A write into a full buffer is dropped rather than overwriting it
        wr_tb     = wr_go & (paddr == `SCT_OFF_TBUF) & s.enabled
                    & ~s.tb_full;
        clr       = (wr_go && paddr == `SCT_OFF_INT_CLR) ? pwdata[1:0] : 2'b00;
    end

    // Next state of the whole block
    always_comb begin
        next_s        = s;
        go_load       = 1'b0;
        ev            = 2'b00;
        next_s.bclk_q = bclk_lvl;

        // Register writes take effect at the edge that samples pready
        if (wr_go) begin
            case (paddr)
                `SCT_OFF_CMD: begin
                    if (pwdata[`SCT_CMD_ENA]) begin
                        next_s.enabled = 1'b1;
                    end
                    // Disable wins; a character in the shifter still completes
                    if (pwdata[`SCT_CMD_DIS]) begin
                        next_s.enabled = 1'b0;
                    end
                end
                `SCT_OFF_MODE: begin
                    next_s.mode = sct_pkg::sct_mode_t'(pwdata[4:0]);
                end
                `SCT_OFF_MODE2: begin
                    next_s.mode2 = sct_pkg::sct_mode2_t'(pwdata[5:0]);
                end
                `SCT_OFF_INT_EN: begin
                    next_s.ien = pwdata[1:0];
                end
                default: begin
                    next_s.ien = s.ien;
                end
            endcase
        end

        // New character into the buffer
        if (wr_tb) begin
            next_s.tbuf    = pwdata[7:0];
            next_s.tb_full = 1'b1;
            next_s.empty   = 1'b0;
        end

        // Serial engine moves only on a falling edge of the clock source
        if (tick) begin
            case (s.phase)
                sct_pkg::SCT_IDLE: begin
                    go_load = can_start;
                end
                sct_pkg::SCT_START: begin
                    if (s.cnt != 6'h00) begin
                        next_s.cnt = s.cnt - 6'h01;
                    end else begin
                        next_s.phase = sct_pkg::SCT_DATA;
                        next_s.txd   = s.shifter[0];
                        next_s.cnt   = bit_len - 6'h01;
                    end
                end
                sct_pkg::SCT_DATA: begin
                    if (s.cnt != 6'h00) begin
                        next_s.cnt = s.cnt - 6'h01;
                    end else if (s.idx != last_idx) begin
                        next_s.idx     = s.idx + 3'h1;
                        next_s.shifter = s.shifter >> 1;
                        next_s.txd     = s.shifter[1];
                        next_s.cnt     = bit_len - 6'h01;
                    end else if (s.mode.par_en) begin
                        next_s.phase = sct_pkg::SCT_PARITY;
                        next_s.txd   = s.par;
                        next_s.cnt   = bit_len - 6'h01;
                    end else begin
                        // Stop starts right after the last data bit
                        next_s.phase = sct_pkg::SCT_STOP;
                        next_s.txd   = 1'b1;
                        next_s.cnt   = stop_len - 6'h01;
                    end
                end
                sct_pkg::SCT_PARITY: begin
                    if (s.cnt != 6'h00) begin
                        next_s.cnt = s.cnt - 6'h01;
                    end else begin
                        next_s.phase = sct_pkg::SCT_STOP;
                        next_s.txd   = 1'b1;
                        next_s.cnt   = stop_len - 6'h01;
                    end
                end
                sct_pkg::SCT_STOP: begin
                    if (s.cnt != 6'h00) begin
                        next_s.cnt = s.cnt - 6'h01;
                    end else begin
                        go_load = can_start;
                        if (!can_start) begin
                            // Line stays at mark while nothing may go
                            next_s.phase = sct_pkg::SCT_IDLE;
                            if (!s.tb_full && !wr_tb) begin
                                next_s.empty = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    next_s.phase = sct_pkg::SCT_IDLE;
                    next_s.txd   = 1'b1;
                end
            endcase
        end

        // Take the waiting character; clear-to-send is not looked at again
        if (go_load) begin
            next_s.shifter = s.tbuf & data_mask;
            next_s.par     = (^(s.tbuf & data_mask)) ^ s.mode.par_odd;
            next_s.tb_full = 1'b0;
            next_s.phase   = sct_pkg::SCT_START;
            next_s.txd     = 1'b0;
            next_s.cnt     = bit_len - 6'h01;
            next_s.idx     = 3'h0;
        end

        // Sticky events; a new event beats a clear in the same cycle
        next_s.ready_q          = next_s.enabled & ~next_s.tb_full;
        ev[`SCT_EVT_READY]      = next_s.ready_q & ~s.ready_q;
        ev[`SCT_EVT_EMPTY]      = next_s.empty & ~s.empty;
        next_s.ist              = (s.ist & ~clr) | ev;
        next_s.irq              = |(next_s.ist & next_s.ien);

        // APB answer one cycle into the access phase
        next_s.pready  = acc;
        next_s.pslverr = 1'b0;
        if (acc) begin
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                `SCT_OFF_CMD, `SCT_OFF_TBUF, `SCT_OFF_INT_CLR: begin
                    next_s.prdata = 32'h0000_0000;
                end
                `SCT_OFF_MODE: begin
                    next_s.prdata = {27'h0, s.mode};
                end
                `SCT_OFF_MODE2: begin
                    next_s.prdata = {26'h0, s.mode2};
                end
                `SCT_OFF_STATUS: begin
                    next_s.prdata = {28'h0, (s.phase != sct_pkg::SCT_IDLE),
                                     s.enabled, s.empty, s.ready_q};
                end
                `SCT_OFF_INT_ST: begin
                    next_s.prdata = {30'h0, s.ist};
                end
                `SCT_OFF_INT_EN: begin
                    next_s.prdata = {30'h0, s.ien};
                end
                default: begin
                    next_s.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign prdata           = s.prdata;
    assign pready           = s.pready;
    assign pslverr          = s.pslverr;
    assign serial_tx_output = s.txd;
    assign irq              = s.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Line only moves one cycle after a clock source falling edge
    a_tx_on_fall:
    assert property (!$stable(s.txd) |-> $past(tick))
        else $error("Serial output changed without a falling edge");

    // Idle line sits at mark
    a_idle_mark:
    assert property (s.phase == sct_pkg::SCT_IDLE |-> s.txd)
        else $error("Serial output low while idle");

    // Start bit is low throughout its phase
    a_start_low:
    assert property (s.phase == sct_pkg::SCT_START |-> !s.txd)
        else $error("Start bit not low");

    // First data bit is bit zero of the character
    a_lsb_first:
    assert property ((s.phase == sct_pkg::SCT_DATA
                      && $past(s.phase) == sct_pkg::SCT_START)
                     |-> s.txd == $past(s.shifter[0]))
        else $error("First data bit is not the least significant");

    // Negated clear-to-send under gating keeps the engine idle
    a_cts_hold:
    assert property ((s.phase == sct_pkg::SCT_IDLE && s.mode2.cts_gate
                      && cts_n_lvl) |=> s.phase == sct_pkg::SCT_IDLE)
        else $error("Character started while clear-to-send negated");

    // A started character is not back at idle one cycle after entering its data phase, whatever the pin
    a_cts_no_abort:
    assert property ((s.phase == sct_pkg::SCT_DATA
                      && $past(s.phase) != sct_pkg::SCT_DATA)
                     |=> s.phase != sct_pkg::SCT_IDLE)
        else $error("Character aborted mid transfer");

    // Accepted buffer write fills the buffer and clears empty
    a_write_clears:
    assert property (wr_tb |=> (s.tb_full && !s.empty))
        else $error("Buffer write did not clear empty");

    // Ready mirrors an enabled channel with room in the buffer
    a_ready_full:
    assert property (s.ready_q == (s.enabled && !s.tb_full))
        else $error("Ready reported with full buffer");

    // Stop length loaded from the code at the start of stop
    a_stop_len:
    assert property ((s.phase == sct_pkg::SCT_STOP
                      && $past(s.phase) != sct_pkg::SCT_STOP
                      && !s.mode.one_x && !s.mode2.stop_sel[3]
                      && s.mode.len != `SCT_LEN_5BIT)
                     |-> s.cnt == {2'b00, s.mode2.stop_sel} + 6'h08)
        else $error("Stop length does not match code");

    // Disabled transmitter starts nothing new
    a_disabled_quiet:
    assert property ((!s.enabled && s.phase == sct_pkg::SCT_IDLE)
                     |=> s.phase == sct_pkg::SCT_IDLE)
        else $error("Transmission started while disabled");

endmodule : sct_transmitter

`default_nettype wire

// >>> dv/sct_line_rx.sv
// Line receiver model: frames characters and times start-to-start gaps
`timescale 1ns/10ps
`default_nettype none

module sct_line_rx (
    input  wire logic        pclk,
    input  wire logic        line,
    input  wire logic [7:0]  bit_pclk,
    input  wire logic [3:0]  nbits,
    output var  logic [8:0]  rx_word,
    output var  logic        stop_ok,
    output var  logic [15:0] gap,
    output var  logic [7:0]  rx_count
);
    time t0;

    // Start edge found, then each cell is sampled at its middle
    initial begin
        t0 = 0;
        rx_count = 8'h00;
        forever begin
            @(negedge line);
            gap = 16'(($time - t0) / 8);
            t0 = $time;
            rx_word = 9'h000;
            repeat (bit_pclk / 2) @(posedge pclk);
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_pclk) @(posedge pclk);
                rx_word[i] = line;
            end
            // Only the middle of the first stop cell is tested
            repeat (bit_pclk) @(posedge pclk);
            stop_ok = line;
            rx_count = rx_count + 8'h01;
        end
    end
endmodule : sct_line_rx
`default_nettype wire

// >>> dv/test_serial_char_transmitter.sv
// Self-checking bench for the serial character transmitter
`timescale 1ns/10ps
`default_nettype none
`include "sct_defs.svh"

module test_serial_char_transmitter;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_clock_source;
    logic        clear_to_send_n;
    logic        serial_tx_output;
    logic        irq;
    logic [7:0]  bit_pclk;
    logic [3:0]  nbits;
    logic [8:0]  rx_word;
    logic        stop_ok;
    logic [15:0] gap;
    logic [7:0]  rx_count;
    logic [2:0]  tick_div;
    logic [31:0] rd_q;
    logic        rd_err;
    logic [7:0]  c0;
    int          mismatches;
    int          samples_checked;
    // Mode, second mode, character, stop length in clock source ticks
    logic [31:0] rows [9] = '{32'h0307a510, 32'h07003c09, 32'h0e08c319,
        32'h010f9620, 32'h00001f11, 32'h04070a18, 32'h00081519, 32'h1307a501, 32'h13085a02};

    sct_transmitter sct_transmitter_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_clock_source(tx_clock_source),
        .clear_to_send_n(clear_to_send_n), .serial_tx_output(serial_tx_output), .irq(irq)
    );

    sct_line_rx sct_line_rx_i (
        .pclk(pclk), .line(serial_tx_output), .bit_pclk(bit_pclk), .nbits(nbits),
        .rx_word(rx_word), .stop_ok(stop_ok), .gap(gap), .rx_count(rx_count)
    );

    // Clock, and a clock source with one falling edge every eight cycles
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        tick_div <= tick_div + 3'h1;
        tx_clock_source <= tick_div[2];
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic hang();
        mismatches++;
        conclude();
    endtask : hang

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // One transfer; the idle cycle first keeps each drive single per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the rising edge that samples pready high
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask : rd

    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `SCT_OFF_STATUS, 32'h0);
            n++;
        end while (rd_q[b] !== v && n < 400);
        if (n >= 400) hang();
    endtask : wait_st

    task automatic wait_rx(input logic [7:0] cnt);
        int n;
        n = 0;
        while (rx_count !== cnt && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) hang();
    endtask : wait_rx

    task automatic wait_low();
        int n;
        n = 0;
        while (serial_tx_output !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) hang();
    endtask : wait_low

    // Two back-to-back characters; the start-to-start gap shows the stop length
    task automatic run_row(input logic [31:0] row);
        logic [7:0] m;
        logic [7:0] m2;
        logic [7:0] ch;
        logic [7:0] st;
        logic [8:0] w;
        {m, m2, ch, st} = row;
        bit_pclk = m[4] ? 8'h08 : 8'h80;
        nbits = 4'h5 + {2'h0, m[1:0]} + {3'h0, m[2]};
        w = {1'b0, ch} & ((9'h001 << (4'h5 + m[1:0])) - 9'h001);
        if (m[2]) w[nbits - 4'h1] = (^w) ^ m[3];
        apb(1'b1, `SCT_OFF_MODE, {24'h0, m});
        apb(1'b1, `SCT_OFF_MODE2, {24'h0, m2});
        c0 = rx_count;
        wait_st(`SCT_EVT_READY, 1'b1);
        apb(1'b1, `SCT_OFF_TBUF, {24'h0, ch});
        wait_st(`SCT_EVT_READY, 1'b1);
        apb(1'b1, `SCT_OFF_TBUF, {24'h0, ch});
        wait_rx(c0 + 8'h02);
        chk("word", {23'h0, w}, {23'h0, rx_word});
        chk("stop", 32'h1, {31'h0, stop_ok});
        chk("gap", (32'h1 + nbits) * bit_pclk + st * 32'h8, {16'h0, gap});
        wait_st(`SCT_EVT_EMPTY, 1'b1);
        chk("status", 32'h7, rd_q);
    endtask : run_row

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_clock_source = 1'b1;
        clear_to_send_n = 1'b1;
        tick_div = 3'h0;
        bit_pclk = 8'h80;
        nbits = 4'h8;
        mismatches = 0;
        samples_checked = 0;
        do_reset();
        apb(1'b1, `SCT_OFF_INT_EN, 32'h3);
        apb(1'b1, `SCT_OFF_CMD, 32'h1);
        // Formats run with clear-to-send negated and gating off
        for (int r = 0; r < 9; r++) run_row(rows[r]);
        // Both events latched; mask and clear act on the level output
        rd("int_st", `SCT_OFF_INT_ST, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `SCT_OFF_INT_EN, 32'h1);
        apb(1'b1, `SCT_OFF_INT_CLR, 32'h1);
        rd("int_st", `SCT_OFF_INT_ST, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, `SCT_OFF_INT_CLR, 32'h2);
        rd("int_st", `SCT_OFF_INT_ST, 32'h0);
        // A second reset in mid-run restores rest values
        do_reset();
        @(negedge pclk);
        chk("line", 32'h1, {31'h0, serial_tx_output});
        chk("irq", 32'h0, {31'h0, irq});
        rd("status", `SCT_OFF_STATUS, 32'h2);
        rd("mode", `SCT_OFF_MODE, 32'h3);
        rd("mode2", `SCT_OFF_MODE2, 32'h7);
        rd("unmapped", 8'h20, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rd_err});
        // A character written while disabled is dropped
        apb(1'b1, `SCT_OFF_TBUF, 32'h55);
        rd("status", `SCT_OFF_STATUS, 32'h2);
        apb(1'b1, `SCT_OFF_CMD, 32'h1);
        rd("status", `SCT_OFF_STATUS, 32'h7);
        // Gating with request-to-send also on holds the character back
        bit_pclk = 8'h80;
        nbits = 4'h8;
        apb(1'b1, `SCT_OFF_MODE2, 32'h37);
        c0 = rx_count;
        apb(1'b1, `SCT_OFF_TBUF, 32'h5a);
        repeat (20) apb(1'b0, `SCT_OFF_STATUS, 32'h0);
        chk("held", 32'h4, rd_q);
        chk("line", 32'h1, {31'h0, serial_tx_output});
        clear_to_send_n <= 1'b0;
        wait_low();
        clear_to_send_n <= 1'b1;
        wait_rx(c0 + 8'h01);
        chk("word", 32'h5a, {23'h0, rx_word});
        chk("stop", 32'h1, {31'h0, stop_ok});
        // Disable mid-character: it completes, the waiting one stays unsent
        wait_st(`SCT_EVT_EMPTY, 1'b1);
        apb(1'b1, `SCT_OFF_MODE2, 32'h07);
        apb(1'b1, `SCT_OFF_TBUF, 32'hc3);
        wait_low();
        apb(1'b1, `SCT_OFF_TBUF, 32'h0f);
        apb(1'b1, `SCT_OFF_CMD, 32'h2);
        wait_rx(c0 + 8'h02);
        chk("word", 32'hc3, {23'h0, rx_word});
        wait_st(3, 1'b0);
        chk("status", 32'h0, rd_q);
        chk("count", {24'h0, c0 + 8'h02}, {24'h0, rx_count});
        conclude();
    end
endmodule : test_serial_char_transmitter
`default_nettype wire
